// *** logic/adc_seq_ctrl.sv ***
// Control core of a 10-bit eight-input converter with four sample sequencers.
// Assumes an external converter answering each conv_start with one conv_done
// pulse on the same clock, and configuration held steady while a sequencer runs.
//
// Overview of operation
// RULE1: Four sequencers: 8 steps/8-deep FIFO, two with 4/4, one with 1/1.
// RULE2: Each result word is 32 bits, conversion in the low 10 bits.
// RULE3: A triggered sequence runs its steps back to back without processor help.
// RULE4: A step is one input-select nibble plus one control nibble, same position.
// RULE5: Control nibble: temperature source, step interrupt, end marker, differential.
// RULE6: Input select picks one of eight inputs, 0 to 7.
// RULE7: Sequencer runs only while enabled; software programs it before enabling.
// RULE8: Several steps may select the same input.
// RULE9: Any steps may enable interrupts; each such completed step sets raw interrupt.
// RULE10: Sequence ends after the step carrying the end marker.
// RULE11: FIFOs are circular; each pop returns and removes the oldest word.
// RULE12: Per sequencer, head, tail, full and empty are visible.
// RULE13: Overflow and underflow are recorded per sequencer.
// RULE14: Sequencing runs at the converter rate, 14 to 18 MHz.
// RULE15: Converter rate derived automatically, aiming at 16.667 MHz.
// RULE16: Interrupt line asserts only when raw interrupt set and mask bit one.
// RULE17: Raw status shows all; masked status shows raw and enabled only.
// RULE18: Writing one clears a sequencer interrupt; zero does nothing.
// RULE19: Concurrent triggers served by 2-bit priority, zero first.
// RULE20: Software gives enabled sequencers distinct priorities, else order undefined.
// RULE21: Trigger source per sequencer, including processor and always sources.
// RULE22: Initiate bit starts a sequencer whose source is the processor.
// RULE23: Always trigger at high priority may starve lower sequencers.
// RULE24: Differential pair k samples input 2k positive, 2k+1 negative.
// RULE25: No averaging: every result goes straight into the FIFO.
// RULE26: Result into full FIFO is dropped and flags overflow; empty pop flags underflow.
// RULE27: Overflow and underflow flags hold until written one.
`timescale 1ns/100ps
`include "adc_seq_defines.svh"
module adc_seq_ctrl import adc_seq_pkg::*; #(
    parameter int NUM_EVT = 4
) (
    // Clock and reset
    input  wire  logic                clk,
    input  wire  logic                rst_n,
    // Configuration
    input  wire  logic [3:0]          sequencer_enable_bit,
    input  wire  logic [3:0][31:0]    step_input_select,
    input  wire  logic [3:0][31:0]    step_control,
    input  wire  logic [3:0][3:0]     trigger_select,
    input  wire  logic [3:0][1:0]     sequencer_priority,
    input  wire  logic [3:0]          interrupt_mask,
    // Write-one strobes
    input  wire  logic [3:0]          initiate_bit,
    input  wire  logic [3:0]          int_clear,
    input  wire  logic [3:0]          ovf_clear,
    input  wire  logic [3:0]          unf_clear,
    // Trigger events from other peripherals
    input  wire  logic [NUM_EVT-1:0]  event_in,
    // Status
    output logic       [3:0]          raw_interrupt_status,
    output logic       [3:0]          interrupt_status,
    output logic       [3:0]          intr,
    output logic       [3:0]          overflow_status,
    output logic       [3:0]          underflow_status,
    output logic       [3:0][2:0]     fifo_head,
    output logic       [3:0][2:0]     fifo_tail,
    output logic       [3:0]          fifo_full,
    output logic       [3:0]          fifo_empty,
    output logic                      busy,
    // Converter
    output logic                      conv_start,
    output logic       [2:0]          conv_pos,
    output logic       [2:0]          conv_neg,
    output logic                      conv_diff,
    output logic                      conv_temp,
    input  wire  logic                conv_done,
    input  wire  logic [`RES_W-1:0]   conv_result,
    // Result pop request
    input  wire  logic                pop_valid,
    input  wire  logic [1:0]          pop_sel,
    output logic                      pop_ready,
    // Popped result
    output logic                      res_valid,
    output logic       [1:0]          res_seq,
    output logic       [`WORD_W-1:0]  res_data,
    input  wire  logic                res_ready
);
    localparam logic [3:0][3:0] DEPTH = {`SS3_DEPTH, `SS2_DEPTH, `SS1_DEPTH, `SS0_DEPTH}; // RULE1
    localparam logic [3:0][4:0] BASE  = {`SS3_BASE, `SS2_BASE, `SS1_BASE, `SS0_BASE};
    localparam logic [15:0] CLK_KHZ  = 16'(`CLK_KHZ);
    localparam logic [15:0] CONV_KHZ = 16'(`CONV_TARGET_KHZ);
    localparam int BUF_W = 2 + `RES_W;

    typedef struct packed {
        seq_state_t        st;
        logic [1:0]        cur;
        logic [2:0]        step;
        logic [3:0]        pend;
        logic [3:0]        raw;
        logic [3:0]        ovf;
        logic [3:0]        unf;
        logic [3:0][2:0]   head;
        logic [3:0][2:0]   tail;
        logic [3:0][3:0]   cnt;
        logic              pop_pend;
        logic [1:0]        pop_seq;
        logic [15:0]       acc;
        logic              conv_start;
        logic [2:0]        pos;
        logic [2:0]        neg;
        logic              diff;
        logic              temp;
        logic [NUM_EVT-1:0] sync1;
        logic [NUM_EVT-1:0] sync2;
        logic [NUM_EVT-1:0] sync3;
        logic [NUM_EVT-1:0] filt;
    } core_t;

    core_t s;
    core_t next_s;

    logic [15:0]        acc_sum;
    logic               conv_en;
    logic [NUM_EVT-1:0] evt_rise;
    logic [3:0]         trig_hit;
    logic               pick_ok;
    logic [1:0]         pick;
    logic [3:0]         cur_sel;
    logic [3:0]         cur_ctl;
    logic               last_step;
    logic               mem_we;
    logic [`MEM_AW-1:0] mem_waddr;
    logic               mem_re;
    logic [`MEM_AW-1:0] mem_raddr;
    logic [`RES_W-1:0]  mem_rdata;
    logic               buf_in_ready;

    stream_if #(.W(BUF_W)) buf_in ();
    stream_if #(.W(BUF_W)) buf_out ();

    function automatic logic [2:0] next_ptr(input logic [2:0] p, input logic [3:0] d);
        return ({1'b0, p} == d - 4'd1) ? 3'd0 : p + 3'd1; // RULE11
    endfunction : next_ptr

    // Fractional divider: one enable per converter clock, from the system clock rate
    assign acc_sum = s.acc + CONV_KHZ; // RULE15
    assign conv_en = (acc_sum >= CLK_KHZ); // RULE14

    // The second and third stages and the filtered level feed the edge detector, never the first stage
    assign evt_rise  = s.sync2 & s.sync3 & ~s.filt;
    assign cur_sel   = step_input_select[s.cur][{s.step, 2'b00} +: 4]; // RULE4 RULE8
    assign cur_ctl   = step_control[s.cur][{s.step, 2'b00} +: 4]; // RULE4
    assign last_step = cur_ctl[`CTL_END] || ({1'b0, s.step} == DEPTH[s.cur] - 4'd1); // RULE10

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            trig_hit[i] = 1'b0;
            unique case (trigger_select[i])
                `TRIG_PROC:   trig_hit[i] = initiate_bit[i]; // RULE22
                `TRIG_ALWAYS: trig_hit[i] = 1'b1; // RULE21 RULE23
                default: begin
                    for (int e = 0; e < NUM_EVT; e++) begin
                        if (trigger_select[i] == 4'(e + 1) && evt_rise[e]) begin
                            trig_hit[i] = 1'b1; // RULE21
                        end
                    end
                end
            endcase
        end
    end

    // Lowest priority value wins; ties go to the lower index but are undefined to software
    always_comb begin
        pick_ok = 1'b0;
        pick    = 2'd0;
        for (int i = 0; i < 4; i++) begin
            if (s.pend[i] && sequencer_enable_bit[i] &&
                (!pick_ok || sequencer_priority[i] < sequencer_priority[pick])) begin // RULE19 RULE20
                pick_ok = 1'b1;
                pick    = 2'(i);
            end
        end
    end

    assign pop_ready = !s.pop_pend && buf_in_ready;

    always_comb begin
        next_s            = s;
        next_s.conv_start = 1'b0;
        next_s.pop_pend   = 1'b0;
        mem_we            = 1'b0;
        mem_waddr         = '0;
        mem_re            = 1'b0;
        mem_raddr         = '0;
        next_s.acc        = conv_en ? acc_sum - CLK_KHZ : acc_sum;
        // Clears first, so a hardware set later in this process wins
        next_s.raw        = s.raw & ~int_clear; // RULE18
        next_s.ovf        = s.ovf & ~ovf_clear; // RULE27
        next_s.unf        = s.unf & ~unf_clear; // RULE27
        next_s.sync1      = event_in;
        next_s.sync2      = s.sync1;
        next_s.sync3      = s.sync2;
        for (int e = 0; e < NUM_EVT; e++) begin
            if (s.sync2[e] == s.sync3[e]) begin
                next_s.filt[e] = s.sync3[e];
            end
        end
        unique case (s.st)
            SEQ_IDLE: begin
                if (pick_ok) begin
                    next_s.cur        = pick; // RULE19
                    next_s.step       = 3'd0;
                    next_s.pend[pick] = 1'b0;
                    next_s.st         = SEQ_ISSUE;
                end
            end
            SEQ_ISSUE: begin
                if (!sequencer_enable_bit[s.cur]) begin
                    next_s.st = SEQ_IDLE; // RULE7
                end else if (conv_en) begin
                    next_s.conv_start = 1'b1; // RULE3
                    next_s.diff       = cur_ctl[`CTL_DIFF]; // RULE5
                    next_s.temp       = cur_ctl[`CTL_TEMP]; // RULE5
                    next_s.pos        = cur_ctl[`CTL_DIFF] ? {cur_sel[1:0], 1'b0}
                                                           : cur_sel[2:0]; // RULE6 RULE24
                    next_s.neg        = {cur_sel[1:0], 1'b1}; // RULE24
                    next_s.st         = SEQ_CONVERT;
                end
            end
            SEQ_CONVERT: begin
                if (conv_done) begin
                    if (s.cnt[s.cur] == DEPTH[s.cur]) begin
                        next_s.ovf[s.cur] = 1'b1; // RULE26 RULE13
                    end else begin
                        mem_we                = 1'b1; // RULE25
                        mem_waddr             = BASE[s.cur] + 5'(s.tail[s.cur]);
                        next_s.tail[s.cur]    = next_ptr(s.tail[s.cur], DEPTH[s.cur]);
                        next_s.cnt[s.cur]     = s.cnt[s.cur] + 4'd1;
                    end
                    if (cur_ctl[`CTL_IE]) begin
                        next_s.raw[s.cur] = 1'b1; // RULE9
                    end
                    if (last_step || !sequencer_enable_bit[s.cur]) begin
                        next_s.st = SEQ_IDLE; // RULE10 RULE7
                    end else begin
                        next_s.step = s.step + 3'd1; // RULE3
                        next_s.st   = SEQ_ISSUE;
                    end
                end
            end
            default: next_s.st = SEQ_IDLE;
        endcase
        // Trigger capture after the idle clear, so a fresh trigger is never lost
        for (int i = 0; i < 4; i++) begin
            if (!sequencer_enable_bit[i]) begin
                next_s.pend[i] = 1'b0; // RULE7
            end else if (trig_hit[i]) begin
                next_s.pend[i] = 1'b1;
            end
        end
        // Pop: reads the oldest word, which lands in the buffer a cycle later
        if (pop_valid && pop_ready) begin
            if (next_s.cnt[pop_sel] == 4'd0 || s.cnt[pop_sel] == 4'd0) begin
                next_s.unf[pop_sel] = 1'b1; // RULE26 RULE13
            end else begin
                mem_re               = 1'b1; // RULE11
                mem_raddr            = BASE[pop_sel] + 5'(s.head[pop_sel]);
                next_s.head[pop_sel] = next_ptr(s.head[pop_sel], DEPTH[pop_sel]);
                next_s.cnt[pop_sel]  = next_s.cnt[pop_sel] - 4'd1;
                next_s.pop_pend      = 1'b1;
                next_s.pop_seq       = pop_sel;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    result_mem #(
        .DEPTH (`MEM_WORDS),
        .AW    (`MEM_AW),
        .W     (`RES_W)
    ) u_mem (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (conv_result),
        .re    (mem_re),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    assign buf_in.valid  = s.pop_pend;
    assign buf_in.data   = {s.pop_seq, mem_rdata};
    assign buf_in_ready  = buf_in.ready;
    assign buf_out.ready = res_ready;

    pair_buffer #(.W(BUF_W)) u_buf (
        .clk   (clk),
        .rst_n (rst_n),
        .up    (buf_in),
        .dn    (buf_out)
    );

    assign res_valid = buf_out.valid;
    assign res_seq   = buf_out.data[BUF_W-1 -: 2];
    assign res_data  = {{(`WORD_W - `RES_W){1'b0}}, buf_out.data[`RES_W-1:0]}; // RULE2

    assign raw_interrupt_status = s.raw; // RULE17
    assign interrupt_status     = s.raw & interrupt_mask; // RULE17
    assign intr                 = s.raw & interrupt_mask; // RULE16
    assign overflow_status      = s.ovf; // RULE13
    assign underflow_status     = s.unf; // RULE13
    assign busy                 = (s.st != SEQ_IDLE);
    assign conv_start           = s.conv_start;
    assign conv_pos             = s.pos;
    assign conv_neg             = s.neg;
    assign conv_diff            = s.diff;
    assign conv_temp            = s.temp;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            fifo_head[i]  = s.head[i]; // RULE12
            fifo_tail[i]  = s.tail[i]; // RULE12
            fifo_full[i]  = (s.cnt[i] == DEPTH[i]); // RULE12
            fifo_empty[i] = (s.cnt[i] == 4'd0); // RULE12
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_STEP_ADVANCE: assert property ( // RULE3
        s.st == SEQ_CONVERT && conv_done && !last_step && sequencer_enable_bit[s.cur]
        |=> s.st == SEQ_ISSUE && s.step == $past(s.step) + 3'd1 ##[1:2] conv_start)
        else $error("sequence did not continue to the next step");

    AST_END_STOPS: assert property ( // RULE10
        s.st == SEQ_CONVERT && conv_done && cur_ctl[`CTL_END] |=> s.st == SEQ_IDLE)
        else $error("sequence ran past its end marker");

    AST_RUN_ENABLED: assert property ( // RULE7
        $rose(conv_start) |-> $past(sequencer_enable_bit[s.cur]))
        else $error("conversion started for a disabled sequencer");

    AST_STEP_IRQ: assert property ( // RULE9
        s.st == SEQ_CONVERT && conv_done && cur_ctl[`CTL_IE] && !int_clear[s.cur]
        ##1 !int_clear[$past(s.cur)] |-> raw_interrupt_status[$past(s.cur, 2)])
        else $error("step interrupt not raised");

    AST_MASK_GATE: assert property ( // RULE16
        intr != 4'h0 |-> (intr & ~(interrupt_mask & raw_interrupt_status)) == 4'h0)
        else $error("interrupt line without mask and raw status");

    AST_OVF_DROP: assert property ( // RULE26
        s.st == SEQ_CONVERT && conv_done && fifo_full[s.cur] && !(pop_valid && pop_ready)
        |=> overflow_status[$past(s.cur)] && fifo_full[$past(s.cur)])
        else $error("overflow not flagged or FIFO changed");

    AST_UNF_FLAG: assert property ( // RULE26
        pop_valid && pop_ready && fifo_empty[pop_sel]
        |=> underflow_status[$past(pop_sel)] && !buf_in.valid)
        else $error("empty pop not flagged");

    AST_FLAG_HOLD: assert property ( // RULE27
        overflow_status[0] && !ovf_clear[0] |=> overflow_status[0])
        else $error("overflow flag dropped without a clear");

    AST_PRIORITY: assert property ( // RULE19
        s.st == SEQ_IDLE && pick_ok |=> s.st == SEQ_ISSUE
        && sequencer_priority[s.cur] <= $past(sequencer_priority[pick]))
        else $error("lower priority sequencer served first");

    AST_CONV_RATE: assert property ( // RULE14
        conv_start |=> !conv_start)
        else $error("converter started on back to back cycles");
endmodule : adc_seq_ctrl

// *** logic/adc_seq_defines.svh ***
// Offsets, field positions, depths and timing figures of the sample sequencer block.
// Included by the control core adc_seq_ctrl only; holds definitions only.
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// System clock and converter clock target, in kHz
`define CLK_KHZ          20000
`define CONV_TARGET_KHZ  16667

// Steps and result FIFO depth of each sequencer
`define SS0_DEPTH        4'd8
`define SS1_DEPTH        4'd4
`define SS2_DEPTH        4'd4
`define SS3_DEPTH        4'd1

// Word base of each FIFO in the shared result memory
`define SS0_BASE         5'h00
`define SS1_BASE         5'h08
`define SS2_BASE         5'h0c
`define SS3_BASE         5'h10
`define MEM_WORDS        17
`define MEM_AW           5

// Bit positions inside a step control nibble
`define CTL_DIFF         0
`define CTL_END          1
`define CTL_IE           2
`define CTL_TEMP         3

// Trigger source codes; codes 1..events select an event input
`define TRIG_PROC        4'h0
`define TRIG_ALWAYS      4'hf

`define RES_W            10
`define WORD_W           32
`endif

// *** logic/adc_seq_pkg.sv ***
// Types shared by the sample sequencer modules.
// Assumes adc_seq_defines.svh for the figures themselves.
package adc_seq_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_ISSUE   = 2'b01,
        SEQ_CONVERT = 2'b10
    } seq_state_t;
endpackage : adc_seq_pkg

// *** logic/pair_buffer.sv ***
// Two-entry buffer on the popped result path; a stall downstream loses no word.
// Assumes producer honours up.ready; data out come straight from a register.
`timescale 1ns/100ps
module pair_buffer #(parameter int W = 12) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Channels
    stream_if.snk     up,
    stream_if.src     dn
);
    typedef struct packed {
        logic [1:0][W-1:0] d;
        logic [1:0]        cnt;
    } buf_t;

    buf_t s;
    buf_t next_s;

    assign up.ready = (s.cnt != 2'd2);
    assign dn.valid = (s.cnt != 2'd0);
    assign dn.data  = s.d[0];

    always_comb begin
        next_s = s;
        if (dn.valid && dn.ready) begin
            next_s.d[0] = s.d[1];
            next_s.cnt  = s.cnt - 2'd1;
        end
        if (up.valid && up.ready) begin
            next_s.d[next_s.cnt[0]] = up.data;
            next_s.cnt              = next_s.cnt + 2'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    AST_BUF_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        dn.valid && !dn.ready |=> dn.valid && $stable(dn.data))
        else $error("buffered word changed while stalled");
endmodule : pair_buffer

// *** logic/result_mem.sv ***
// Shared result memory of all sequencer FIFOs, one write and one read port.
// Assumes the caller keeps addresses below DEPTH; read data arrive one cycle later.
`timescale 1ns/100ps
module result_mem #(
    parameter int DEPTH = 17,
    parameter int AW    = 5,
    parameter int W     = 10
) (
    // Clock and reset
    input  wire  logic          clk,
    input  wire  logic          rst_n,
    // Write port
    input  wire  logic          we,
    input  wire  logic [AW-1:0] waddr,
    input  wire  logic [W-1:0]  wdata,
    // Read port
    input  wire  logic          re,
    input  wire  logic [AW-1:0] raddr,
    output logic       [W-1:0]  rdata
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (!rst_n) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule : result_mem

// *** logic/stream_if.sv ***
// Valid/ready word channel between the sequencer core and its output buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface stream_if #(parameter int W = 12);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// *** verif/adc_sample_sequencer_control_tb.sv ***
// Random bench of the sequencer core checked against a queue model.
// Assumes conv_model answers every conversion start.
`timescale 1ns/100ps
module adc_sample_sequencer_control_tb;
    logic clk = 1'b0, rst_n = 1'b0, pop_valid, res_ready = 1'b0;
    logic [3:0] sequencer_enable_bit, interrupt_mask, initiate_bit, int_clear, ovf_clear;
    logic [3:0] unf_clear, event_in, raw_interrupt_status, interrupt_status, intr;
    logic [3:0] overflow_status, underflow_status, fifo_full, fifo_empty, ov, un, rw;
    logic [3:0][31:0] step_input_select, step_control;
    logic [3:0][3:0] trigger_select;
    logic [3:0][2:0] fifo_head, fifo_tail;
    logic [3:0][1:0] sequencer_priority;
    logic busy, conv_start, conv_diff, conv_temp, conv_done, pop_ready, res_valid;
    logic [2:0] conv_pos, conv_neg, lag;
    logic [9:0] conv_result;
    logic [1:0] pop_sel, res_seq;
    logic [31:0] res_data, seed = 32'h523e;
    int dep[4] = '{8, 4, 4, 1};
    int q[4][$], seen[$], hd[4], tl[4], bad_count, comparisons, cycles;
    adc_seq_ctrl #(.NUM_EVT(4)) dut (.clk, .rst_n, .sequencer_enable_bit, .step_input_select,
        .step_control, .trigger_select, .sequencer_priority, .interrupt_mask, .initiate_bit,
        .int_clear, .ovf_clear, .unf_clear, .event_in, .raw_interrupt_status,
        .interrupt_status, .intr, .overflow_status, .underflow_status, .fifo_head, .fifo_tail,
        .fifo_full, .fifo_empty, .busy, .conv_start, .conv_pos, .conv_neg, .conv_diff,
        .conv_temp, .conv_done, .conv_result, .pop_valid, .pop_sel, .pop_ready, .res_valid,
        .res_seq, .res_data, .res_ready);
    conv_model cm (.clk, .lag, .conv_start, .conv_pos, .conv_neg, .conv_diff, .conv_temp,
        .conv_done, .conv_result);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic chk(string n, logic [31:0] seen_v, logic [31:0] exp_v);
        comparisons++;
        if (seen_v !== exp_v) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, exp_v, seen_v);
        end
    endtask : chk
    task automatic status();
        for (int s = 0; s < 4; s++) begin
            chk("empty", fifo_empty[s], q[s].size() == 0);
            chk("full", fifo_full[s], q[s].size() == dep[s]);
            chk("head", fifo_head[s], hd[s]);
            chk("tail", fifo_tail[s], tl[s]);
            chk("overflow", overflow_status[s], ov[s]);
            chk("underflow", underflow_status[s], un[s]);
            chk("raw", raw_interrupt_status[s], rw[s]);
            chk("line", intr[s], rw[s] & interrupt_mask[s]);
            chk("masked", interrupt_status[s], rw[s] & interrupt_mask[s]);
        end
    endtask : status
    task automatic push(int s, int v, bit ie);
        if (q[s].size() < dep[s]) begin
            q[s].push_back(v);
            tl[s] = (tl[s] + 1) % dep[s];
        end else ov[s] = 1'b1;
        if (ie) rw[s] = 1'b1;
    endtask : push
    // Clears use the inverted mask for overflow so both polarities get exercised
    task automatic strobe(logic [3:0] ini, logic [3:0] clr);
        int z = 0;
        @(negedge clk);
        initiate_bit = ini;
        int_clear = clr;
        ovf_clear = ~clr & ~ini;
        unf_clear = clr;
        rw &= ~clr;
        ov &= clr | ini;
        un &= ~clr;
        @(negedge clk);
        {initiate_bit, int_clear, ovf_clear, unf_clear} = '0;
        for (int t = 0; t < 400 && z < 2; t++) @(negedge clk) z = busy === 1'b0 ? z + 1 : 0;
        repeat (2) @(negedge clk);
    endtask : strobe
    task automatic pop(int s);
        @(negedge clk);
        pop_valid = 1'b1;
        pop_sel = 2'(s);
        do @(posedge clk); while (pop_ready !== 1'b1);
        @(negedge clk);
        pop_valid = 1'b0;
        if (q[s].size() == 0) un[s] = 1'b1;
        else begin
            hd[s] = (hd[s] + 1) % dep[s];
            do @(posedge clk); while (!(res_valid === 1'b1 && res_ready === 1'b1));
            chk("data", res_data, q[s].pop_front());
            chk("source", res_seq, s);
        end
    endtask : pop
    task automatic run(int s);
        logic [3:0] c;
        logic [2:0] v;
        int n;
        bit e;
        n = rnd() % dep[s];
        e = rnd() % 4 != 0;
        @(negedge clk);
        sequencer_enable_bit[s] = 1'b0;
        lag = 3'(rnd());
        interrupt_mask = 4'(rnd());
        for (int k = 0; k < 8; k++) begin
            c = 4'(rnd());
            c[1] = (k == n) | (c[1] & (k > n));
            v = 3'(c[0] ? rnd() % 4 : rnd() % 8);
            step_input_select[s][4*k+:4] = {1'b0, v};
            step_control[s][4*k+:4] = c;
            if (k <= n && e) push(s, {c[3], c[0], c[0] ? 3'(2*v+1) : 3'h0, 3'(c[0] ? 2*v : v)}, c[2]);
        end
        @(negedge clk);
        sequencer_enable_bit[s] = e;
        strobe(4'h1 << s, 4'h0);
        status();
    endtask : run
    task automatic prio_test();
        int ord[4] = '{0, 1, 2, 3};
        int j, t;
        sequencer_enable_bit = 4'h0;
        for (int i = 0; i < 4; i++) begin
            j = rnd() % 4;
            t = ord[i];
            ord[i] = ord[j];
            ord[j] = t;
        end
        for (int i = 0; i < 4; i++) begin
            sequencer_priority[ord[i]] = 2'(i);
            step_input_select[i][3:0] = 4'(i);
            step_control[i][3:0] = 4'h2;
            push(i, i, 1'b0);
        end
        @(negedge clk);
        sequencer_enable_bit = 4'hf;
        seen.delete();
        strobe(4'hf, 4'h0);
        chk("starts", seen.size(), 4);
        for (int i = 0; i < 4; i++) chk("order", seen[i], ord[i]);
        status();
    endtask : prio_test
    always #25 clk = ~clk;
    always @(negedge clk) res_ready <= rnd() % 4 != 0;
    always @(posedge clk) begin
        if (conv_start === 1'b1) seen.push_back(conv_pos);
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        {sequencer_enable_bit, interrupt_mask, initiate_bit, int_clear, ovf_clear} = '0;
        {unf_clear, event_in, ov, un, rw, pop_valid, pop_sel, lag} = '0;
        {step_input_select, step_control, trigger_select, sequencer_priority} = '0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        status();
        prio_test();
        for (int r = 0; r < 40; r++) begin
            run(rnd() % 4);
            repeat (rnd() % 4) pop(rnd() % 4);
            strobe(4'h0, 4'(rnd()));
            status();
        end
        complete_run();
    end
endmodule : adc_sample_sequencer_control_tb

// *** verif/conv_model.sv ***
// Converter stand-in: one done pulse per conversion start, after lag cycles.
// Assumes the core holds its selects from start until done.
`timescale 1ns/100ps
module conv_model (
    // Clock and delay
    input  wire logic       clk,
    input  wire logic [2:0] lag,
    // Request
    input  wire logic       conv_start,
    input  wire logic [2:0] conv_pos,
    input  wire logic [2:0] conv_neg,
    input  wire logic       conv_diff,
    input  wire logic       conv_temp,
    // Answer
    output logic            conv_done,
    output logic [9:0]      conv_result
);
    logic [9:0] val;
    initial begin
        conv_done   = 1'b0;
        conv_result = 10'h155;
    end
    // Result encodes the selection, so a wrong input shows up in the data
    always @(posedge clk) begin
        if (conv_start === 1'b1) begin
            val = {2'h0, conv_temp, conv_diff, conv_diff ? conv_neg : 3'h0, conv_pos};
            repeat (lag) @(posedge clk);
            conv_done   <= 1'b1;
            conv_result <= val;
            @(posedge clk);
            conv_done   <= 1'b0;
            // Stale data inverted so nothing reads it by luck
            conv_result <= ~val;
        end
    end
endmodule : conv_model
